// [core/serial_isp_pkg.sv]
// Shared constants for the serial flash programming decoder
package serial_isp_pkg;
  // ------------------------------------------------------------
  // System clock and instruction encodings
  // ------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam logic [7:0] OP_PREFIX = 8'hac;
  localparam logic [7:0] EN_KEY = 8'h53;
  localparam logic [7:0] EN_ECHO = 8'h69;
  localparam logic [2:0] ERASE_PAT = 3'h4;
  localparam logic [5:0] LOCK_PAT = 6'h38;
  localparam logic [7:0] OP_RD_BYTE = 8'h20;
  localparam logic [7:0] OP_WR_BYTE = 8'h40;
  localparam logic [7:0] OP_RD_LOCK = 8'h24;
  localparam logic [7:0] OP_RD_PAGE = 8'h30;
  localparam logic [7:0] OP_WR_PAGE = 8'h50;
  // ------------------------------------------------------------
  // Layout and reset values
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int LOCK_LSB = 2;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [7:0] IDLE_TX = 8'h00;
  localparam logic [1:0] LAST_IDX = 2'h3;
  localparam logic [7:0] LAST_OFS = 8'hff;
  // ------------------------------------------------------------
  // Timing: erase 500 ms, byte write 64 oscillator periods + 400 us
  // ------------------------------------------------------------
  localparam int ERASE_MS = 500;
  localparam int ERASE_CYC = ERASE_MS * (CLK_HZ / 1000);
  localparam int WR_OSC = 64;
  localparam int WR_US = 400;
  localparam int WR_CYC = WR_OSC + WR_US * (CLK_HZ / 1_000_000);
endpackage : serial_isp_pkg

// [core/serial_isp_ifs.sv]
// Interfaces between the decoder, its link shifter and its flash store
`timescale 1ns/1ps
`default_nettype none
interface link_if;
  logic [7:0] rx_byte;
  logic rx_tgl;
  logic [7:0] tx_byte;
  modport link (output rx_byte, output rx_tgl, input tx_byte);
  modport ctrl (input rx_byte, input rx_tgl, output tx_byte);
endinterface : link_if

interface flash_if;
  logic [11:0] rd_addr;
  logic [7:0] rd_data;
  logic wr_en;
  logic [11:0] wr_addr;
  logic [7:0] wr_data;
  logic erase;
  logic busy;
  modport mem (input rd_addr, output rd_data, input wr_en, input wr_addr,
    input wr_data, input erase, output busy);
  modport ctrl (output rd_addr, input rd_data, output wr_en, output wr_addr,
    output wr_data, output erase, input busy);
endinterface : flash_if
`default_nettype wire

// [core/link_shifter.sv]
// Serial-clock side shifter: bytes in on rising edge, out on falling edge
`timescale 1ns/1ps
`default_nettype none
module link_shifter (
  input wire logic sck_in,
  input wire logic rst_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  link_if.link lk
);
  typedef struct packed {
    logic [2:0] cnt;
    logic [6:0] sh;
    logic [7:0] rx;
    logic tgl;
  } rise_t;
  typedef struct packed {
    logic [7:0] sh;
  } fall_t;
  rise_t r_ff;
  rise_t nxt_r;
  fall_t f_ff;
  fall_t nxt_f;

  // Receive MSB first; a full byte is held and flagged by a toggle
  always_comb begin
    nxt_r = r_ff;
    nxt_r.cnt = r_ff.cnt + 3'h1;
    nxt_r.sh = {r_ff.sh[5:0], mosi_in}; // R16 R21
    if (r_ff.cnt == 3'h7) begin
      nxt_r.rx = {r_ff.sh, mosi_in};
      nxt_r.tgl = ~r_ff.tgl;
    end
  end

  always_ff @(posedge sck_in or negedge rst_n_in) begin
    if (!rst_n_in) r_ff <= '0;
    else r_ff <= nxt_r;
  end

  // Reply byte is taken whole at the last falling edge of the byte before;
  // the word is settled by then only while the serial clock is slow
  always_comb begin
    nxt_f = f_ff;
    if (r_ff.cnt == 3'h0) nxt_f.sh = lk.tx_byte; // R15
    else nxt_f.sh = {f_ff.sh[6:0], 1'b0}; // R16 R21
  end

  always_ff @(negedge sck_in or negedge rst_n_in) begin
    if (!rst_n_in) f_ff <= '0;
    else f_ff <= nxt_f;
  end

  assign miso_out = f_ff.sh[7];
  assign lk.rx_byte = r_ff.rx;
  assign lk.rx_tgl = r_ff.tgl;
endmodule : link_shifter
`default_nettype wire

// [core/flash_store.sv]
// Program flash array with timed erase and byte write cycles
`timescale 1ns/1ps
`default_nettype none
module flash_store
  import serial_isp_pkg::*;
#(
  parameter int ERASE_CYC_P = ERASE_CYC
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  flash_if.mem fl
);
  typedef struct packed {
    logic [31:0] tmr;
    logic erasing;
    logic [11:0] eidx;
    logic [11:0] la;
    logic [7:0] ld;
  } fst_t;
  fst_t st_ff;
  fst_t nxt;
  logic [7:0] mem [0:(1 << ADDR_W) - 1];
  logic busy;
  logic take_wr;

  assign busy = (st_ff.tmr != 32'h0) || st_ff.erasing;
  // Writes are refused only while the array is being wiped or an erase is requested
  assign take_wr = fl.wr_en && !st_ff.erasing && !fl.erase;

  // Cycle timers; each write restarts the write window
  always_comb begin
    nxt = st_ff;
    if (st_ff.tmr != 32'h0) nxt.tmr = st_ff.tmr - 32'h1;
    if (st_ff.erasing) begin
      nxt.eidx = st_ff.eidx + 12'h1;
      if (st_ff.eidx == 12'hfff) nxt.erasing = 1'b0;
    end
    if (fl.erase && !st_ff.erasing) begin
      nxt.erasing = 1'b1;
      nxt.eidx = 12'h0;
      nxt.tmr = 32'(ERASE_CYC_P); // R17
    end else if (take_wr) begin
      nxt.la = fl.wr_addr;
      nxt.ld = fl.wr_data;
      nxt.tmr = 32'(WR_CYC); // R18
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) st_ff <= '0;
    else st_ff <= nxt;
  end

  // Array cells carry no reset, as a real flash would not
  always_ff @(posedge clk_in) begin
    if (st_ff.erasing) mem[st_ff.eidx] <= ERASED; // R2
    else if (take_wr) mem[fl.wr_addr] <= fl.wr_data;
  end

  // Polling the last written byte shows its MSB inverted until done
  assign fl.rd_data = (busy && fl.rd_addr == st_ff.la) ?
    {~st_ff.ld[7], st_ff.ld[6:0]} : mem[fl.rd_addr]; // R19
  assign fl.busy = busy;
endmodule : flash_store
`default_nettype wire

// [core/serial_isp_command_decoder.sv]
// Serial in-system programming instruction decoder, top level
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: Enable key AC 53 xx xx, echo 69
// R2: AC with 100xxxxx erases whole array
// R3: Opcode 20 reads addressed byte in byte four
// R4: Opcode 40 writes byte four to address
// R5: AC with 111000xx writes selected lock mode
// R6: Select 01/10/11 sets lock bit 1/2/3
// R7: Programmer raises lock modes in ascending order
// R8: Opcode 24 returns lock bits, programmed reads one
// R9: Opcode 30 streams 256 page bytes out
// R10: Opcode 50 takes 256 page bytes in
// R11: Page data runs offset 0 up to 255
// R12: Page bytes are data until 256 passed
// R13: Serial clock low 64 clocks after reset
// R14: Enable needs no reset pulse
// R15: Serial clock at most one sixteenth system clock
// R16: Sample MOSI rising, change MISO falling
// R17: Chip erase completes within 500 ms
// R18: Byte write within 64 periods plus 400 us
// R19: Polling busy byte returns inverted MSB
// R20: Instructions are four-byte frames, decoded complete
// R21: Bytes travel most significant bit first
// R22: Only enable accepted before enable; reset exits
module serial_isp_command_decoder
  import serial_isp_pkg::*;
#(
  parameter int ERASE_CYC_P = ERASE_CYC
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic prog_rst_in,
  input wire logic sck_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic prog_enabled_out,
  output logic busy_out,
  output logic [2:0] lock_bits_out
);
  // ------------------------------------------------------------
  // Types and state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    FRAME,
    PAGE_RD,
    PAGE_WR
  } mode_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic en;
    mode_t mode;
    logic [1:0] idx;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] pofs;
    logic [7:0] tx;
    logic [2:0] lock;
    logic wr_en;
    logic [11:0] wr_addr;
    logic [7:0] wr_data;
    logic erase;
  } st_t;

  st_t st_ff;
  st_t nxt_st;
  logic link_rst_n;
  logic rx_evt;
  logic [7:0] rx_byte;
  logic [11:0] rd_addr;

  link_if lk ();
  flash_if fl ();

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  // Programming enable key in bytes one and two
  function automatic logic is_enable(input logic [7:0] c1,
                                     input logic [7:0] c2);
    is_enable = (c1 == OP_PREFIX) && (c2 == EN_KEY);
  endfunction : is_enable

  // Chip erase: prefix with 100x xxxx
  function automatic logic is_erase(input logic [7:0] c1,
                                    input logic [7:0] c2);
    is_erase = (c1 == OP_PREFIX) && (c2[7:5] == ERASE_PAT);
  endfunction : is_erase

  // Lock write: prefix with 1110 00xx
  function automatic logic is_lock_wr(input logic [7:0] c1,
                                      input logic [7:0] c2);
    is_lock_wr = (c1 == OP_PREFIX) && (c2[7:2] == LOCK_PAT);
  endfunction : is_lock_wr

  // Lock select pair to the bits it programs
  function automatic logic [2:0] lock_sel(input logic [1:0] sel);
    case (sel)
      2'h1: lock_sel = 3'h1; // R6
      2'h2: lock_sel = 3'h2; // R6
      2'h3: lock_sel = 3'h4; // R6
      default: lock_sel = 3'h0; // R6
    endcase
  endfunction : lock_sel

  // ------------------------------------------------------------
  // Serial link side
  // ------------------------------------------------------------
  // The link is held in reset whenever the target reset pin is low,
  // so byte framing restarts at the first edge after entry; the
  // programmer keeps the clock low across that release
  assign link_rst_n = arst_n_in & prog_rst_in; // R13 R21 R22

  link_shifter u_link (
    .sck_in(sck_in),
    .rst_n_in(link_rst_n),
    .mosi_in(mosi_in),
    .miso_out(miso_out),
    .lk(lk.link)
  );

  // ------------------------------------------------------------
  // Flash array
  // ------------------------------------------------------------
  flash_store #(
    .ERASE_CYC_P(ERASE_CYC_P)
  ) u_flash (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .fl(fl.mem)
  );

  // Received byte arrives as a held word plus a toggle; the word
  // stays still for a whole byte time, far beyond the sync delay
  assign rx_evt = st_ff.rx_s2 != st_ff.rx_s3;
  assign rx_byte = lk.rx_byte;

  // ------------------------------------------------------------
  // Instruction sequencer
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    rd_addr = {st_ff.b2[3:0], rx_byte};
    // Synchronisers: the first stage feeds only the second
    nxt_st.rst_s1 = prog_rst_in;
    nxt_st.rst_s2 = st_ff.rst_s1;
    nxt_st.rx_s1 = lk.rx_tgl;
    nxt_st.rx_s2 = st_ff.rx_s1;
    nxt_st.rx_s3 = st_ff.rx_s2;
    // Strobes to the array last one cycle
    nxt_st.wr_en = 1'b0;
    nxt_st.erase = 1'b0;
    if (!st_ff.rst_s2) begin
      // Target reset low: programming mode is left at once
      nxt_st.en = 1'b0; // R22
      nxt_st.mode = FRAME;
      nxt_st.idx = 2'h0;
      nxt_st.tx = IDLE_TX;
    end else if (rx_evt) begin
      case (st_ff.mode)
        // Page streams: each byte is data, never an opcode
        PAGE_RD: begin
          rd_addr = {st_ff.b2[3:0], 8'(st_ff.pofs + 8'h01)}; // R11
          nxt_st.tx = fl.rd_data; // R9
          nxt_st.pofs = st_ff.pofs + 8'h01;
          if (st_ff.pofs == LAST_OFS) begin
            nxt_st.mode = FRAME; // R12
            nxt_st.idx = 2'h0;
            nxt_st.tx = IDLE_TX;
          end
        end
        PAGE_WR: begin
          nxt_st.wr_en = 1'b1; // R10
          nxt_st.wr_addr = {st_ff.b2[3:0], st_ff.pofs}; // R11
          nxt_st.wr_data = rx_byte;
          nxt_st.pofs = st_ff.pofs + 8'h01;
          if (st_ff.pofs == LAST_OFS) begin
            nxt_st.mode = FRAME; // R12
            nxt_st.idx = 2'h0;
          end
        end
        FRAME: begin
          nxt_st.idx = st_ff.idx + 2'h1;
          case (st_ff.idx)
            // Byte one: opcode
            2'h0: begin
              nxt_st.b1 = rx_byte;
              nxt_st.tx = IDLE_TX;
            end
            // Byte two: sub-code or upper address; page opcodes
            // switch to streaming right after it
            2'h1: begin
              nxt_st.b2 = rx_byte;
              nxt_st.pofs = 8'h00; // R11
              if (st_ff.en && st_ff.b1 == OP_RD_PAGE) begin
                nxt_st.mode = PAGE_RD; // R9 R12
                rd_addr = {rx_byte[3:0], 8'h00};
                nxt_st.tx = fl.rd_data; // R9
              end else if (st_ff.en && st_ff.b1 == OP_WR_PAGE) begin
                nxt_st.mode = PAGE_WR; // R10 R12
              end
            end
            // Byte three: low address; reply for byte four is
            // prepared here so it is ready for its first bit
            2'h2: begin
              nxt_st.b3 = rx_byte;
              if (is_enable(st_ff.b1, st_ff.b2)) begin
                nxt_st.tx = EN_ECHO; // R1
              end else if (st_ff.en && st_ff.b1 == OP_RD_BYTE) begin
                rd_addr = {st_ff.b2[3:0], rx_byte}; // R3
                nxt_st.tx = fl.rd_data; // R3 R19
              end else if (st_ff.en && st_ff.b1 == OP_RD_LOCK) begin
                nxt_st.tx = 8'(st_ff.lock) << LOCK_LSB; // R8
              end else begin
                nxt_st.tx = IDLE_TX;
              end
            end
            // Byte four: the frame is whole, act on it now
            default: begin
              nxt_st.tx = IDLE_TX;
              if (is_enable(st_ff.b1, st_ff.b2)) begin
                nxt_st.en = 1'b1; // R1 R14 R20
              end else if (!st_ff.en) begin
                nxt_st.en = 1'b0; // R22
              end else if (is_erase(st_ff.b1, st_ff.b2)) begin
                nxt_st.erase = 1'b1; // R2 R20
                nxt_st.lock = 3'h0;
              end else if (st_ff.b1 == OP_WR_BYTE) begin
                nxt_st.wr_en = 1'b1; // R4 R20
                nxt_st.wr_addr = {st_ff.b2[3:0], st_ff.b3};
                nxt_st.wr_data = rx_byte;
              end else if (is_lock_wr(st_ff.b1, st_ff.b2)) begin
                // A lock write only sets bits; mode one changes nothing
                nxt_st.lock = st_ff.lock | lock_sel(st_ff.b2[1:0]); // R5 R7
              end
            end
          endcase
          if (st_ff.idx == LAST_IDX) nxt_st.idx = 2'h0; // R20
        end
        default: begin
          nxt_st.mode = FRAME;
          nxt_st.idx = 2'h0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs and link connections
  // ------------------------------------------------------------
  // Reply word is a flop; the link samples it at byte start
  assign lk.tx_byte = st_ff.tx; // R15
  assign fl.rd_addr = rd_addr;
  assign fl.wr_en = st_ff.wr_en;
  assign fl.wr_addr = st_ff.wr_addr;
  assign fl.wr_data = st_ff.wr_data;
  assign fl.erase = st_ff.erase;
  assign prog_enabled_out = st_ff.en;
  assign busy_out = fl.busy; // R17 R18
  assign lock_bits_out = st_ff.lock;
endmodule : serial_isp_command_decoder
`default_nettype wire

// [test/serial_isp_props.sv]
// Port checker for the serial programming decoder
`timescale 1ns/1ps
`default_nettype none
module serial_isp_props #(
  parameter int ERASE_CYC_P = 5000
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic prog_rst_in,
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic miso_out,
  input wire logic prog_enabled_out,
  input wire logic busy_out,
  input wire logic [2:0] lock_bits_out
);
  // -----
  // Busy stretch counter
  // -----
  localparam int BUSY_MAX = ERASE_CYC_P + 4200;
  int busy_cnt_ff;
  // Restarts on serial activity, since page writes keep busy up
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_cnt_ff <= 0;
    end else begin
      busy_cnt_ff <= (!busy_out || sck_in) ? 0 : busy_cnt_ff + 1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // -----
  // Properties
  // -----
  property p_exit; !prog_rst_in [*5] |-> !prog_enabled_out; endproperty
  a_exit: assert property (p_exit) else $error("mode kept with pin low");
  property p_busy_bound; busy_cnt_ff <= BUSY_MAX; endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
  property p_miso_fall; $changed(miso_out) |-> !sck_in; endproperty
  a_miso_fall: assert property (p_miso_fall) else $error("miso moved, sck high");
  property p_en_sck; $rose(prog_enabled_out) |-> sck_in; endproperty
  a_en_sck: assert property (p_en_sck) else $error("enable off frame end");
  property p_busy_sck; $rose(busy_out) |-> sck_in; endproperty
  a_busy_sck: assert property (p_busy_sck) else $error("busy off frame end");
  property p_busy_en; $rose(busy_out) |-> prog_enabled_out; endproperty
  a_busy_en: assert property (p_busy_en) else $error("busy while locked out");
  property p_lock_set; (|(lock_bits_out & ~$past(lock_bits_out))) |-> prog_enabled_out;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock set, not enabled");
  property p_lock_clr;
    (|($past(lock_bits_out) & ~lock_bits_out)) |-> ##[0:2] busy_out;
  endproperty
  a_lock_clr: assert property (p_lock_clr) else $error("lock cleared w/o erase");
endmodule : serial_isp_props
bind serial_isp_command_decoder serial_isp_props #(.ERASE_CYC_P(ERASE_CYC_P)) u_props (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .prog_rst_in(prog_rst_in), .sck_in(sck_in),
  .mosi_in(mosi_in), .miso_out(miso_out), .prog_enabled_out(prog_enabled_out),
  .busy_out(busy_out), .lock_bits_out(lock_bits_out));
`default_nettype wire

// [test/isp_programmer.sv]
// Behavioural serial programmer on the link pins
`timescale 1ns/1ps
`default_nettype none
module isp_programmer (
  input wire logic lclk_in,
  input wire logic miso_in,
  output logic sck_out,
  output logic mosi_out,
  output logic [7:0] rx_byte_out,
  output logic rx_tgl_out
);
  int half = 134; // Link ticks a half period, 8 system clocks at least
  // Serial clock idles low between frames
  initial begin
    sck_out = 1'b0;
    mosi_out = 1'b0;
    rx_byte_out = 8'h00;
    rx_tgl_out = 1'b0;
  end
  // One byte each way, most significant bit first
  task automatic xfer(input logic [7:0] b);
    logic [7:0] r;
    @(posedge lclk_in);
    for (int i = 7; i >= 0; i--) begin
      mosi_out <= b[i];
      repeat (half) @(posedge lclk_in);
      sck_out <= 1'b1;
      repeat (half) @(posedge lclk_in);
      r[i] = miso_in;
      sck_out <= 1'b0;
    end
    mosi_out <= ~b[0];
    rx_byte_out <= r;
    rx_tgl_out <= ~rx_tgl_out;
  endtask : xfer
endmodule : isp_programmer
`default_nettype wire

// [test/serial_isp_command_decoder_tb.sv]
// Self-checking bench for the serial programming decoder
`timescale 1ns/1ps
`default_nettype none
module serial_isp_command_decoder_tb;
  import serial_isp_pkg::*;
  localparam int ERASE_P = 5000;
  logic clk_in = 1'b0;
  logic lclk = 1'b0;
  logic arst_n_in = 1'b0;
  logic prog_rst_in = 1'b0;
  logic sck, mosi, miso, en, busy, rx_tgl;
  logic [2:0] lock;
  logic [7:0] rx_byte, d;
  logic [15:0] t;
  logic [11:0] a;
  logic [3:0] p;
  logic [8:0] exp_q[$];
  logic [7:0] page_d[256];
  logic [31:0] seed = 32'he98b5849;
  int n_errors = 0;
  int compares = 0;
  // System clock, and a link clock of unrelated phase
  always #50 clk_in = ~clk_in;
  initial begin
    #1.3;
    forever #3 lclk = ~lclk;
  end
  serial_isp_command_decoder #(.ERASE_CYC_P(ERASE_P)) DUT (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .prog_rst_in(prog_rst_in), .sck_in(sck),
    .mosi_in(mosi), .miso_out(miso), .prog_enabled_out(en), .busy_out(busy),
    .lock_bits_out(lock));
  isp_programmer PRG (.lclk_in(lclk), .miso_in(miso), .sck_out(sck), .mosi_out(mosi),
    .rx_byte_out(rx_byte), .rx_tgl_out(rx_tgl));
  // -----
  // Helpers
  // -----
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic print_verdict();
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  // Byte with its reply note; unchecked notes keep the queue aligned
  task automatic xb(input logic [7:0] b, input logic c, input logic [7:0] e);
    exp_q.push_back({c, e});
    PRG.xfer(b);
  endtask : xb
  task automatic frame(input logic [7:0] b0, b1, b2, b3, input logic c,
                       input logic [7:0] e);
    xb(b0, 1'b0, 8'h00);
    xb(b1, 1'b0, 8'h00);
    xb(b2, 1'b0, 8'h00);
    xb(b3, c, e);
  endtask : frame
  task automatic wait_idle(input int lim);
    int k;
    k = 0;
    while (busy !== 1'b0 && k < lim) begin
      @(negedge clk_in);
      k++;
    end
    if (busy !== 1'b0) begin
      n_errors++;
      print_verdict();
    end
  endtask : wait_idle
  // Reply monitor takes the oldest note per received byte
  always @(rx_tgl) begin
    if (exp_q.size() > 0) begin
      if (exp_q[0][8]) begin
        check(rx_byte, exp_q[0][7:0]);
      end
      exp_q.delete(0);
    end
  end
  // -----
  // Main sequence
  // -----
  initial begin
    repeat (8) @(negedge clk_in);
    arst_n_in = 1'b1;
    @(negedge clk_in);
    prog_rst_in = 1'b1;
    repeat (70) @(negedge clk_in);
    frame(OP_PREFIX, 8'h80, 8'h00, 8'h00, 1'b0, 8'h00);
    frame(OP_RD_LOCK, 8'h00, 8'h00, 8'h00, 1'b1, IDLE_TX);
    check({6'h00, busy, en}, 8'h00);
    frame(OP_PREFIX, EN_KEY, rnd(), rnd(), 1'b1, EN_ECHO);
    repeat (8) @(negedge clk_in);
    check({7'h00, en}, 8'h01);
    for (int m = 0; m < 4; m++) begin
      frame(OP_PREFIX, {LOCK_PAT, 2'(m)}, rnd(), rnd(), 1'b0, 8'h00);
      repeat (4) @(negedge clk_in);
      check({5'h00, lock}, (8'h01 << m) - 8'h01);
    end
    frame(OP_RD_LOCK, rnd(), rnd(), 8'h00, 1'b1, {3'h0, 3'h7, 2'h0});
    frame(OP_PREFIX, {ERASE_PAT, 5'h15}, rnd(), rnd(), 1'b0, 8'h00);
    check({7'h00, busy}, 8'h01);
    wait_idle(ERASE_P + 5000);
    check({5'h00, lock}, 8'h00);
    t = {rnd(), rnd()};
    a = t[11:0];
    d = rnd();
    frame(OP_WR_BYTE, {4'h0, a[11:8]}, a[7:0], d, 1'b0, 8'h00);
    frame(OP_RD_BYTE, {4'h0, a[11:8]}, a[7:0], 8'h00, 1'b1, {~d[7], d[6:0]});
    wait_idle(WR_CYC + 100);
    frame(OP_RD_BYTE, {4'h0, a[11:8]}, a[7:0], 8'h00, 1'b1, d);
    a = a ^ 12'h001;
    frame(OP_RD_BYTE, {4'h0, a[11:8]}, a[7:0], 8'h00, 1'b1, ERASED);
    t = {rnd(), rnd()};
    p = t[3:0];
    xb(OP_WR_PAGE, 1'b0, 8'h00);
    xb({4'h0, p}, 1'b0, 8'h00);
    for (int i = 0; i < 256; i++) begin
      page_d[i] = rnd();
      xb(page_d[i], 1'b0, 8'h00);
    end
    wait_idle(WR_CYC + 100);
    xb(OP_RD_PAGE, 1'b0, 8'h00);
    xb({4'h0, p}, 1'b1, IDLE_TX);
    for (int i = 0; i < 256; i++) begin
      xb(8'h00, 1'b1, page_d[i]);
    end
    PRG.half = 268;
    frame(OP_RD_BYTE, {4'h0, p}, 8'hff, 8'h00, 1'b1, page_d[255]);
    prog_rst_in = 1'b0;
    repeat (8) @(negedge clk_in);
    check({7'h00, en}, 8'h00);
    print_verdict();
  end
endmodule : serial_isp_command_decoder_tb
`default_nettype wire
